// [verilog/nbci_pkg.sv]
// Constants, command codes and enumerations for the NAND bus host sequencer.
// Assumes a 20 MHz system clock and one attached small-page NAND device.
package nbci_pkg;

  // System clock period and the pin phase timing, in nanoseconds.
  localparam int CLK_NS = 50;
  localparam int PHASE_NS = 150;
  localparam int BUSY_SETTLE_NS = 200;
  // Cycle counts derived from the times above; least times round up.
  localparam int PHASE_CYC = (PHASE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC = (BUSY_SETTLE_NS + CLK_NS - 1) / CLK_NS;

  // Single-cycle command codes sent on the low byte lines.
  localparam logic [7:0] CODE_PTR_A = 8'h00;
  localparam logic [7:0] CODE_PTR_B = 8'h01;
  localparam logic [7:0] CODE_PTR_C = 8'h50;
  localparam logic [7:0] CODE_SIGN = 8'h90;
  localparam logic [7:0] CODE_STAT = 8'h70;
  localparam logic [7:0] CODE_RST = 8'hFF;
  localparam logic [7:0] CODE_PROG = 8'h80;
  localparam logic [7:0] CODE_PCONF = 8'h10;
  localparam logic [7:0] CODE_COPY = 8'h8A;
  localparam logic [7:0] CODE_ERASE = 8'h60;
  localparam logic [7:0] CODE_ECONF = 8'hD0;

  // Address field positions and the number of address cycles.
  localparam int ADDR_W = 27;
  localparam int COL_LSB = 0;
  localparam int ROW1_LSB = 9;
  localparam int ROW2_LSB = 17;
  localparam int PLANE_LSB = 25;
  localparam logic [1:0] ADDR_LAST = 2'h3;
  localparam logic [1:0] ERASE_FIRST = 2'h1;

  // Operations the user side may request.
  typedef enum logic [2:0] {
    NBCI_OP_READ = 3'h0,
    NBCI_OP_PROG = 3'h1,
    NBCI_OP_ERASE = 3'h2,
    NBCI_OP_COPY = 3'h3,
    NBCI_OP_STAT = 3'h4,
    NBCI_OP_SIGN = 3'h5,
    NBCI_OP_RST = 3'h6
  } nbci_op_t;

  // Area pointer choices for read and program.
  typedef enum logic [1:0] {
    NBCI_AREA_A = 2'h0,
    NBCI_AREA_B = 2'h1,
    NBCI_AREA_C = 2'h2
  } nbci_area_t;

  // Sequencer states, one-hot.
  typedef enum logic [7:0] {
    NBCI_ST_IDLE = 8'h01,
    NBCI_ST_PTR = 8'h02,
    NBCI_ST_CMD = 8'h04,
    NBCI_ST_ADDR = 8'h08,
    NBCI_ST_WDATA = 8'h10,
    NBCI_ST_CONF = 8'h20,
    NBCI_ST_BUSY = 8'h40,
    NBCI_ST_RDATA = 8'h80
  } nbci_state_t;

endpackage : nbci_pkg

// [verilog/nbci_host.sv]
// NAND bus host sequencer and its program-data FIFO.
// Assumes the device pins are sampled synchronously to clk_i and that the
// bench resolves the shared data lines from the output enable.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Synchronous FIFO, flip-flop storage, valid/ready on both sides.
module nbci_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Filling side.
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // Draining side.
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];  // Storage words.
  logic [AW-1:0] wr_ptr_r;  // Next slot to write.
  logic [AW-1:0] rd_ptr_r;  // Head slot.
  logic [AW:0] count_r;  // Words held.
  logic push;
  logic pop;

  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];

  // Storage write; data needs no reset.
  always_ff @(posedge clk_i)
  begin
    if (push)
    begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
      in_ready_o <= 1'b1;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      // Ready is kept in a flop so the fill side sees a registered output.
      if (push && !pop)
      begin
        count_r <= count_r + 1'b1;
        in_ready_o <= (count_r != (AW + 1)'(DEPTH - 1));
      end
      else if (pop && !push)
      begin
        count_r <= count_r - 1'b1;
        in_ready_o <= 1'b1;
      end
    end
  end
endmodule : nbci_fifo

////////////////////////////////////////////////////////////////////////////////
// Host sequencer: turns one user request into a full pin sequence.
module nbci_host #(
  parameter int LEN_W = 10,
  parameter int FIFO_DEPTH = 16,
  parameter bit BIG_DENSITY = 1'b1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Request port.
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire nbci_pkg::nbci_op_t cmd_op_i,
  input wire nbci_pkg::nbci_area_t cmd_area_i,
  input wire logic [nbci_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [nbci_pkg::ADDR_W-1:0] cmd_addr2_i,
  input wire logic [LEN_W-1:0] cmd_len_i,
  input wire logic wide_i,
  output logic done_o,
  // Program data stream.
  input wire logic wr_valid_i,
  input wire logic [15:0] wr_data_i,
  output logic wr_ready_o,
  // Read data stream.
  output logic rd_valid_o,
  output logic [15:0] rd_data_o,
  // Device pins.
  output logic chip_on_n_o,
  output logic cmd_phase_sel_o,
  output logic addr_phase_sel_o,
  output logic input_latch_n_o,
  output logic fetch_pulse_n_o,
  output logic protect_n_o,
  output logic [15:0] dq_o,
  output logic dq_oe_n_o,
  input wire logic [15:0] dq_i,
  input wire logic ready_busy_i
);
  import nbci_pkg::*;

  nbci_state_t state_r;  // Sequencer state.
  nbci_op_t op_r;  // Operation in progress.
  nbci_area_t area_r;  // Pointer chosen for it.
  logic [ADDR_W-1:0] addr_r;  // Current address.
  logic [ADDR_W-1:0] addr2_r;  // Copy-back target.
  logic [LEN_W-1:0] len_r;  // Data words to move.
  logic [LEN_W-1:0] cnt_r;  // Word or address cycle index.
  logic stage2_r;  // Copy-back target stage.
  logic [7:0] div_r;  // Phase divider.
  logic tick;  // One-cycle phase enable.
  logic [1:0] ph_r;  // Bus cycle phase: setup, strobe low, strobe high.
  logic [7:0] settle_r;  // Wait before trusting the busy line.
  logic is_wr;  // State issues write cycles.
  logic stall;  // No program word ready yet.
  logic cyc_done;  // Bus cycle ends this clock.
  logic [7:0] wr_byte;  // Byte for command or address cycles.
  logic [7:0] ptr_code;  // Pointer code for the chosen area.
  logic fifo_valid;
  logic [15:0] fifo_data;
  logic fifo_pop;

  ////////////////////////////////////////////////////////////////////////////
  // Program data buffer; the sequencer stalls while it is empty.
  nbci_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(wr_valid_i),
    .in_data_i(wr_data_i),
    .in_ready_o(wr_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fifo_pop)
  );

  assign cmd_ready_o = state_r[0];
  assign is_wr = (state_r == NBCI_ST_PTR) || (state_r == NBCI_ST_CMD) ||
                 (state_r == NBCI_ST_ADDR) || (state_r == NBCI_ST_WDATA) ||
                 (state_r == NBCI_ST_CONF);
  assign stall = (state_r == NBCI_ST_WDATA) && !fifo_valid;
  assign cyc_done = tick && (ph_r == 2'h2);
  assign fifo_pop = cyc_done && (state_r == NBCI_ST_WDATA);

  // Pointer code; the second-half code is never sent in wide mode.
  always_comb
  begin
    case (area_r)
      NBCI_AREA_B: ptr_code = wide_i ? CODE_PTR_A : CODE_PTR_B;
      NBCI_AREA_C: ptr_code = CODE_PTR_C;
      default: ptr_code = CODE_PTR_A;
    endcase
  end

  // Byte placed on the low lines for command and address cycles.
  always_comb
  begin
    wr_byte = 8'h00;
    if (state_r == NBCI_ST_ADDR)
    begin
      // The half-page bit never travels in an address cycle.
      case (cnt_r[1:0])
        2'h0: wr_byte = addr_r[COL_LSB +: 8];
        2'h1: wr_byte = addr_r[ROW1_LSB +: 8];
        2'h2: wr_byte = addr_r[ROW2_LSB +: 8];
        default: wr_byte = {6'h00, addr_r[PLANE_LSB + 1] & BIG_DENSITY, addr_r[PLANE_LSB]};
      endcase
    end
    else if (state_r == NBCI_ST_PTR)
    begin
      wr_byte = ptr_code;
    end
    else if (state_r == NBCI_ST_CONF)
    begin
      wr_byte = (op_r == NBCI_OP_PROG) ? CODE_PCONF : CODE_ECONF;
    end
    else
    begin
      case (op_r)
        NBCI_OP_READ: wr_byte = ptr_code;
        NBCI_OP_PROG: wr_byte = CODE_PROG;
        NBCI_OP_ERASE: wr_byte = CODE_ERASE;
        NBCI_OP_COPY: wr_byte = stage2_r ? CODE_COPY : CODE_PTR_A;
        NBCI_OP_STAT: wr_byte = CODE_STAT;
        NBCI_OP_SIGN: wr_byte = CODE_SIGN;
        default: wr_byte = CODE_RST;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase divider: one enable pulse every PHASE_CYC clocks.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_r[0])
    begin
      div_r <= '0;
    end
    else
    begin
      div_r <= (div_r == 8'(PHASE_CYC - 1)) ? 8'h00 : div_r + 8'h01;
    end
  end
  assign tick = (div_r == 8'(PHASE_CYC - 1));

  // Bus cycle phase; holds in setup while a program word is missing.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || state_r[0] || state_r == NBCI_ST_BUSY)
    begin
      ph_r <= 2'h0;
    end
    else if (tick && !stall)
    begin
      ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: walks setup, address, data, confirm and busy wait.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= NBCI_ST_IDLE;
      op_r <= NBCI_OP_READ;
      area_r <= NBCI_AREA_A;
      addr_r <= '0;
      addr2_r <= '0;
      len_r <= '0;
      cnt_r <= '0;
      stage2_r <= 1'b0;
      settle_r <= '0;
      done_o <= 1'b0;
    end
    else
    begin
      done_o <= 1'b0;
      case (state_r)
        NBCI_ST_IDLE:
        begin
          if (cmd_valid_i)
          begin
            op_r <= cmd_op_i;
            area_r <= (cmd_op_i == NBCI_OP_COPY) ? NBCI_AREA_A : cmd_area_i;
            addr_r <= cmd_addr_i;
            addr2_r <= cmd_addr2_i;
            len_r <= (cmd_op_i == NBCI_OP_STAT) ? LEN_W'(1) : cmd_len_i;
            stage2_r <= 1'b0;
            cnt_r <= '0;
            state_r <= (cmd_op_i == NBCI_OP_PROG) ? NBCI_ST_PTR : NBCI_ST_CMD;
          end
        end
        NBCI_ST_PTR:
        begin
          if (cyc_done)
          begin
            state_r <= NBCI_ST_CMD;
          end
        end
        NBCI_ST_CMD:
        begin
          if (cyc_done)
          begin
            // Erase sends only the row cycles.
            cnt_r <= (op_r == NBCI_OP_ERASE) ? LEN_W'(ERASE_FIRST) : '0;
            settle_r <= '0;
            case (op_r)
              NBCI_OP_STAT, NBCI_OP_SIGN: state_r <= NBCI_ST_RDATA;
              NBCI_OP_RST: state_r <= NBCI_ST_BUSY;
              default: state_r <= NBCI_ST_ADDR;
            endcase
          end
        end
        NBCI_ST_ADDR:
        begin
          if (cyc_done)
          begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r[1:0] == ADDR_LAST)
            begin
              // Index 3 is always the last cycle: four cycles, or three for erase.
              cnt_r <= '0;
              settle_r <= '0;
              case (op_r)
                NBCI_OP_PROG: state_r <= NBCI_ST_WDATA;
                NBCI_OP_ERASE: state_r <= NBCI_ST_CONF;
                default: state_r <= NBCI_ST_BUSY;
              endcase
            end
          end
        end
        NBCI_ST_WDATA:
        begin
          if (cyc_done)
          begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == len_r - 1'b1)
            begin
              state_r <= NBCI_ST_CONF;
            end
          end
        end
        NBCI_ST_CONF:
        begin
          if (cyc_done)
          begin
            settle_r <= '0;
            state_r <= NBCI_ST_BUSY;
          end
        end
        NBCI_ST_BUSY:
        begin
          // Nothing new is issued until the device reports ready.
          if (settle_r != 8'(SETTLE_CYC))
          begin
            settle_r <= settle_r + 8'h01;
          end
          else if (ready_busy_i)
          begin
            cnt_r <= '0;
            if (op_r == NBCI_OP_READ)
            begin
              state_r <= NBCI_ST_RDATA;
            end
            else if (op_r == NBCI_OP_COPY && !stage2_r)
            begin
              // Target stage; the optional trailing confirm is omitted.
              stage2_r <= 1'b1;
              addr_r <= addr2_r;
              state_r <= NBCI_ST_CMD;
            end
            else
            begin
              done_o <= 1'b1;
              state_r <= NBCI_ST_IDLE;
            end
          end
        end
        NBCI_ST_RDATA:
        begin
          if (cyc_done)
          begin
            cnt_r <= cnt_r + 1'b1;
            if (cnt_r == len_r - 1'b1)
            begin
              done_o <= 1'b1;
              state_r <= NBCI_ST_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= NBCI_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read capture: one word per read strobe, sampled late in its low phase.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
    end
    else
    begin
      rd_valid_o <= (state_r == NBCI_ST_RDATA) && tick && (ph_r == 2'h1);
      if ((state_r == NBCI_ST_RDATA) && tick && (ph_r == 2'h1))
      begin
        rd_data_o <= wide_i ? dq_i : {8'h00, dq_i[7:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin drivers, registered from state and phase.
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      chip_on_n_o <= 1'b1;
      cmd_phase_sel_o <= 1'b0;
      addr_phase_sel_o <= 1'b0;
      input_latch_n_o <= 1'b1;
      fetch_pulse_n_o <= 1'b1;
      protect_n_o <= 1'b0;
      dq_o <= 16'h0000;
      dq_oe_n_o <= 1'b1;
    end
    else
    begin
      // Deselected in idle, so the device stands by.
      chip_on_n_o <= state_r[0];
      cmd_phase_sel_o <= (state_r == NBCI_ST_PTR) || (state_r == NBCI_ST_CMD) ||
                         (state_r == NBCI_ST_CONF);
      addr_phase_sel_o <= (state_r == NBCI_ST_ADDR);
      input_latch_n_o <= !(is_wr && (ph_r == 2'h1));
      fetch_pulse_n_o <= !((state_r == NBCI_ST_RDATA) && (ph_r == 2'h1));
      // Protect released only inside program, erase and copy-back.
      protect_n_o <= !state_r[0] && ((op_r == NBCI_OP_PROG) ||
                     (op_r == NBCI_OP_ERASE) || (op_r == NBCI_OP_COPY));
      // Bus is released outside write cycles so the device may drive it.
      dq_oe_n_o <= !is_wr;
      if (state_r == NBCI_ST_WDATA)
      begin
        dq_o <= wide_i ? fifo_data : {8'h00, fifo_data[7:0]};
      end
      else
      begin
        dq_o <= {8'h00, wr_byte};
      end
    end
  end

endmodule : nbci_host

// [tb/nbci_chk_sva.sv]
// Pin checker for the NAND bus host sequencer.
// Assumes registered pins and a synchronous active-low reset.
`timescale 1ns/1ps
module nbci_chk (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Watched outputs.
  input wire logic cmd_ready_o,
  input wire logic done_o,
  input wire logic rd_valid_o,
  input wire logic chip_on_n_o,
  input wire logic cmd_phase_sel_o,
  input wire logic addr_phase_sel_o,
  input wire logic input_latch_n_o,
  input wire logic fetch_pulse_n_o,
  input wire logic protect_n_o,
  input wire logic [15:0] dq_o,
  input wire logic dq_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_latch_needs_chip: assert property (!input_latch_n_o |-> !chip_on_n_o)
    else $error("write strobe low with chip off");
  a_no_drive_read: assert property (!fetch_pulse_n_o |-> dq_oe_n_o && input_latch_n_o)
    else $error("host drives or strobes during read");
  a_sel_exclusive: assert property (!(cmd_phase_sel_o && addr_phase_sel_o))
    else $error("both phase selects high");
  a_sel_no_fetch: assert property ((cmd_phase_sel_o || addr_phase_sel_o)
    |-> fetch_pulse_n_o)
    else $error("read strobe low in command or address phase");
  a_latch_stable: assert property ($rose(input_latch_n_o)
    |-> $stable(dq_o) && $stable(cmd_phase_sel_o) && $stable(addr_phase_sel_o) && !dq_oe_n_o)
    else $error("bus changed at write strobe edge");
  a_prot_high: assert property ($rose(input_latch_n_o) && cmd_phase_sel_o
    && (dq_o[7:0] == 8'h80 || dq_o[7:0] == 8'h60 || dq_o[7:0] == 8'h10 || dq_o[7:0] == 8'hD0)
    |-> protect_n_o)
    else $error("program or erase code sent while protected");
  a_word_per_fetch: assert property ($fell(fetch_pulse_n_o) |-> ##[1:8] rd_valid_o)
    else $error("no read word after read strobe");
  a_idle_quiet: assert property (cmd_ready_o [*3]
    |-> chip_on_n_o && !protect_n_o && dq_oe_n_o)
    else $error("pins active while idle");
  a_done_ready: assert property (done_o |-> cmd_ready_o ##1 !done_o)
    else $error("done without ready or longer than one cycle");
endmodule : nbci_chk

////////////////////////////////////////////////////////////////////////////////
bind nbci_host nbci_chk chk_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .cmd_ready_o(cmd_ready_o),
  .done_o(done_o), .rd_valid_o(rd_valid_o), .chip_on_n_o(chip_on_n_o),
  .cmd_phase_sel_o(cmd_phase_sel_o), .addr_phase_sel_o(addr_phase_sel_o),
  .input_latch_n_o(input_latch_n_o), .fetch_pulse_n_o(fetch_pulse_n_o),
  .protect_n_o(protect_n_o), .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o));

// [tb/nbci_dev.sv]
// Behavioural NAND device that answers the host sequencer.
// Assumes its pins are sampled on the host clock; logs every latched byte.
`timescale 1ns/1ps
module nbci_dev #(
  parameter int BUSY_CYC = 12,
  parameter logic [15:0] SIGN_VAL = 16'h3C5A // Arbitrary signature value.
) (
  // Clock and pins.
  input wire logic clk_i,
  input wire logic chip_on_n_i,
  input wire logic cmd_sel_i,
  input wire logic addr_sel_i,
  input wire logic latch_n_i,
  input wire logic fetch_n_i,
  input wire logic protect_n_i,
  input wire logic [15:0] dq_i,
  output logic [15:0] dq_o,
  output logic rb_o
);
  logic [9:0] log_q[$]; // Latched bytes with kind: 1 command, 2 address, 3 data.
  logic l_r = 1'b1, f_r = 1'b1;
  logic [7:0] code_r = 8'h00, setup_r = 8'h00, idx_r = 8'h00, b;
  logic [2:0] nadr_r = 3'h0;
  logic [7:0] ptr_r = 8'h00; // Area pointer code: first half, second half or spare.
  logic [15:0] word, last_r = 16'h0000;
  int busy_r = 0;
  assign b = dq_i[7:0];
  assign rb_o = (busy_r == 0);
  assign word = (code_r == 8'h70) ? 16'h00E0 :
                (code_r == 8'h90) ? SIGN_VAL : {8'hC3, 8'h5A ^ idx_r};
  // Released lines toggle so a stale value never looks valid.
  assign dq_o = (!chip_on_n_i && latch_n_i && !cmd_sel_i && !addr_sel_i && !fetch_n_i) ?
                word : ~last_r;
  // Decode each write strobe rise by the select levels.
  always @(posedge clk_i)
  begin
    l_r <= latch_n_i;
    f_r <= fetch_n_i;
    last_r <= dq_o;
    if (busy_r > 0) busy_r <= busy_r - 1;
    if (!f_r && fetch_n_i && !chip_on_n_i) idx_r <= idx_r + 8'h01;
    if (!l_r && latch_n_i && !chip_on_n_i && fetch_n_i)
    begin
      if (cmd_sel_i && !addr_sel_i && (busy_r == 0 || b == 8'h70 || b == 8'hFF))
      begin
        log_q.push_back({2'h1, b});
        code_r <= b;
        idx_r <= 8'h00;
        nadr_r <= 3'h0;
        if (b == 8'h80 || b == 8'h60) setup_r <= b;
        if (b == 8'hFF) busy_r <= BUSY_CYC;
        if (b == 8'h00 || b == 8'h01 || b == 8'h50) ptr_r <= b;
        if (protect_n_i && ((b == 8'h10 && setup_r == 8'h80) || (b == 8'hD0 && setup_r == 8'h60)))
          busy_r <= BUSY_CYC;
      end
      else if (addr_sel_i && !cmd_sel_i)
      begin
        log_q.push_back({2'h2, b});
        nadr_r <= nadr_r + 3'h1;
        // The second-half pointer is spent by one array load.
        if (nadr_r == 3'h3 && ptr_r == 8'h01) ptr_r <= 8'h00;
        // Only the fourth cycle starts an array load; extras are ignored.
        if (nadr_r == 3'h3 && (code_r == 8'h00 || code_r == 8'h01 || code_r == 8'h50
            || (code_r == 8'h8A && protect_n_i))) busy_r <= BUSY_CYC;
      end
      else if (!addr_sel_i && !cmd_sel_i) log_q.push_back({2'h3, b});
    end
  end
endmodule : nbci_dev

// [tb/testbench.sv]
// Self-checking bench for the NAND bus host sequencer with a device model.
// Assumes the model answers on the resolved data lines.
`timescale 1ns/1ps
module testbench;
  import nbci_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, wide = 1'b0, wr_valid = 1'b0;
  nbci_op_t op = NBCI_OP_READ;
  nbci_area_t area = NBCI_AREA_A;
  logic [26:0] addr = 27'h6D5A3A5, addr2 = 27'h12C4E7B;
  logic [9:0] len = 10'h001;
  logic [15:0] wr_data = 16'h0000, dq_host, dq_dev, dq_bus, rd_data;
  logic cmd_ready, done, wr_ready, rd_valid, chip_n, csel, asel, latch_n, fetch_n, prot_n;
  logic oe_n, rb;
  logic [15:0] rdq[$];
  logic [9:0] exq[$];
  int fails = 0, n_checks = 0;
  always #25 clk = ~clk;
  assign dq_bus = oe_n ? dq_dev : dq_host;
  always @(posedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
  nbci_host dut_u (.clk_i(clk), .rst_n_i(rst_n), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
    .cmd_op_i(op), .cmd_area_i(area), .cmd_addr_i(addr), .cmd_addr2_i(addr2), .cmd_len_i(len),
    .wide_i(wide), .done_o(done), .wr_valid_i(wr_valid), .wr_data_i(wr_data),
    .wr_ready_o(wr_ready), .rd_valid_o(rd_valid), .rd_data_o(rd_data), .chip_on_n_o(chip_n),
    .cmd_phase_sel_o(csel), .addr_phase_sel_o(asel), .input_latch_n_o(latch_n),
    .fetch_pulse_n_o(fetch_n), .protect_n_o(prot_n), .dq_o(dq_host), .dq_oe_n_o(oe_n),
    .dq_i(dq_bus), .ready_busy_i(rb));
  nbci_dev dev_u (.clk_i(clk), .chip_on_n_i(chip_n), .cmd_sel_i(csel), .addr_sel_i(asel),
    .latch_n_i(latch_n), .fetch_n_i(fetch_n), .protect_n_i(prot_n), .dq_i(dq_host),
    .dq_o(dq_dev), .rb_o(rb));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Expected address bytes; erase omits the column cycle.
  task automatic exp_addr(input logic [26:0] a, input bit full);
    if (full) exq.push_back({2'h2, a[7:0]});
    exq.push_back({2'h2, a[16:9]});
    exq.push_back({2'h2, a[24:17]});
    exq.push_back({2'h2, 6'h00, a[26], a[25]});
  endtask : exp_addr
  // Issue one request, wait for done, then compare the device's log.
  task automatic run(input nbci_op_t o, input nbci_area_t ar, input logic [9:0] n);
    int t;
    t = 0;
    rdq.delete();
    dev_u.log_q.delete();
    @(posedge clk);
    op <= o;
    area <= ar;
    len <= n;
    cmd_valid <= 1'b1;
    @(posedge clk);
    cmd_valid <= 1'b0;
    while (done !== 1'b1 && t < 3000)
    begin
      @(posedge clk);
      t++;
    end
    if (t >= 3000)
    begin
      fails++;
      $display("Error done expected 1 seen timeout");
    end
    chk("log length", 16'(exq.size()), 16'(dev_u.log_q.size()));
    foreach (exq[i]) chk("bus write", {6'h00, exq[i]}, {6'h00, dev_u.log_q[i]});
    exq.delete();
  endtask : run
  task automatic t_read(input logic w, input nbci_area_t ar, input logic [7:0] ptr);
    wide <= w;
    exq.push_back({2'h1, ptr});
    exp_addr(addr, 1'b1);
    run(NBCI_OP_READ, ar, 10'h003);
    chk("read count", 16'h0003, 16'(rdq.size()));
    foreach (rdq[i]) chk("read word", {w ? 8'hC3 : 8'h00, 8'h5A ^ 8'(i)}, rdq[i]);
    chk("pointer after read", 16'h0000, {8'h00, dev_u.ptr_r});
  endtask : t_read
  // Fill the FIFO with 16 words, check it refuses more, then program from it.
  task automatic t_prog;
    wide <= 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      @(posedge clk);
      wr_valid <= 1'b1;
      wr_data <= 16'hFF30 + 16'(i);
      exq.push_back({2'h3, 8'h30 + 8'(i)});
    end
    @(posedge clk);
    wr_valid <= 1'b0;
    @(posedge clk);
    chk("fifo full", 16'h0000, {15'h0000, wr_ready});
    exq.push_front({2'h2, 6'h00, addr[26], addr[25]});
    exq.push_front({2'h2, addr[24:17]});
    exq.push_front({2'h2, addr[16:9]});
    exq.push_front({2'h2, addr[7:0]});
    exq.push_front({2'h1, 8'h80});
    exq.push_front({2'h1, 8'h50});
    exq.push_back({2'h1, 8'h10});
    run(NBCI_OP_PROG, NBCI_AREA_C, 10'h010);
    chk("fifo drained", 16'h0001, {15'h0000, wr_ready});
  endtask : t_prog
  task automatic t_erase_copy;
    exq.push_back({2'h1, 8'h60});
    exp_addr(addr, 1'b0);
    exq.push_back({2'h1, 8'hD0});
    run(NBCI_OP_ERASE, NBCI_AREA_A, 10'h001);
    exq.push_back({2'h1, 8'h00});
    exp_addr(addr, 1'b1);
    exq.push_back({2'h1, 8'h8A});
    exp_addr(addr2, 1'b1);
    run(NBCI_OP_COPY, NBCI_AREA_B, 10'h001);
  endtask : t_erase_copy
  task automatic t_single;
    exq.push_back({2'h1, 8'h70});
    run(NBCI_OP_STAT, NBCI_AREA_A, 10'h004);
    chk("status", 16'h00E0, rdq.size() == 1 ? rdq[0] : 16'hFFFF);
    exq.push_back({2'h1, 8'h90});
    run(NBCI_OP_SIGN, NBCI_AREA_A, 10'h002);
    chk("signature", 16'h005A, rdq.size() == 2 ? rdq[1] : 16'hFFFF);
    exq.push_back({2'h1, 8'hFF});
    run(NBCI_OP_RST, NBCI_AREA_A, 10'h001);
  endtask : t_single
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report
  initial
  begin
    #1000000;
    fails++;
    $display("Error watchdog expected finish seen timeout");
    final_report();
  end
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_read(1'b0, NBCI_AREA_B, 8'h01);
    t_read(1'b1, NBCI_AREA_B, 8'h00);
    t_prog();
    t_erase_copy();
    t_single();
    final_report();
  end
endmodule : testbench
